/* core/rcm_top.sv */
// calibration and measurement command core with test observation routing
// How it works
// - regulator start: rx/tx on, maximum setting
// - every 300 us lower one step
// - stop at margin or minimum setting
// - regulator sequence ends within 5 ms
// - refuse regulator command on external selection
// - accept all but test access and test clear only when enabled and oscillator stable
// - depth calibration adapts toward target, 275 us
// - antenna trim tuned to resonance, 250 us
// - phase via converter relative mode, 25 us
// - phase saturates FFh below, 00h above
// - mid-scale code means 90 degree shift
// - four long commands raise termination pulse
// - receive-active rise clears, then peak hold
// - strength clear command zeroes and restarts hold
// - transparent mode from slave-select rise while high
// - supply measure: selected supply, absolute, 25 us
// - test access maps test writes in frame
// - test registers survive frames, cleared by command
// - observe select routes channels to spare pins
// - routing also works in normal operation
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module rcm_top import rcm_pkg::*; #(
	parameter int unsigned REG_WAIT_CYC = `RCM_US2CYC(`RCM_REG_WAIT_US),
	parameter int unsigned REG_TOTAL_CYC = `RCM_US2CYC(`RCM_REG_TOTAL_US),
	parameter int unsigned MOD_CYC = `RCM_US2CYC(`RCM_MOD_TOTAL_US),
	parameter int unsigned ANT_CYC = `RCM_US2CYC(`RCM_ANT_TOTAL_US),
	parameter int unsigned MEAS_CYC = `RCM_US2CYC(`RCM_MEAS_TOTAL_US)
) (
	// core clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// link clock and serial decoder bytes
	input wire logic i_sclk,
	input wire logic i_ss_n,
	input wire logic i_lk_cmd_stb,
	input wire logic [7:0] i_lk_cmd,
	input wire logic i_lk_wr_stb,
	input wire logic [5:0] i_lk_addr,
	input wire logic [7:0] i_lk_wdata,
	// configuration bits from the register file
	input wire logic i_en,
	input wire logic i_ext_reg_sel,
	input wire logic i_supply_measure_select_hi,
	input wire logic i_supply_measure_select_lo,
	input wire logic i_supply_5v,
	input wire logic [7:0] i_md_target,
	// analog status, asynchronous
	input wire logic i_osc_stable,
	input wire logic i_margin_ok,
	input wire logic i_tank_above,
	input wire logic i_am_dig,
	input wire logic i_pm_dig,
	input wire logic i_coll_out,
	input wire logic i_tx_mod,
	// converter
	input wire logic i_adc_done,
	input wire logic [7:0] i_adc_data,
	input wire logic i_adc_over,
	input wire logic i_adc_under,
	// receiver
	input wire logic i_rx_on,
	input wire logic [3:0] i_sig_level,
	// analog controls
	output logic o_rx_force,
	output logic o_tx_force,
	output logic o_phase_det_en,
	output logic o_adc_start,
	output logic [1:0] o_adc_src,
	output logic o_adc_rel,
	output logic [1:0] o_supply_ch,
	output logic [12:0] o_reg_mv,
	output logic [7:0] o_mod_depth,
	output logic [7:0] o_tuning_trim_outputs,
	// results and status
	output logic [7:0] o_adc_result,
	output logic o_irq_term,
	output logic o_busy,
	output logic [3:0] o_signal_strength,
	output logic o_transparent,
	output logic o_test_active,
	output logic [7:0] o_test_rdata,
	// observation pins
	output logic [3:0] o_obs_sel,
	output logic o_observe_pin_a,
	output logic o_observe_pin_a_oe,
	output logic o_observe_pin_b,
	output logic o_observe_pin_b_oe
);
	localparam int unsigned MOD_STEP_CYC = `RCM_US2CYC(`RCM_MOD_STEP_US);
	// eight trim bits share the tuning window, rounded down
	localparam int unsigned ANT_STEP_CYC = ANT_CYC / 8;

	// ==================================================
	// helper functions
	function automatic logic [7:0] phase_code(input logic over, input logic under, input logic [7:0] d);
		// below the lower angle the detector voltage tops out, above the upper it bottoms out
		if (under)
			return `RCM_PHASE_SAT_HI;
		if (over)
			return `RCM_PHASE_SAT_LO;
		return d;
	endfunction

	// {a_oe, a, b_oe, b}; analog selections leave the digital drivers off
	function automatic logic [3:0] obs_route(input logic [3:0] sel, input logic [3:0] ch);
		case (sel)
			`RCM_OBS_AM, `RCM_OBS_AM2: return {2'b00, 1'b1, ch[3]};
			`RCM_OBS_PM: return {2'b00, 1'b1, ch[2]};
			`RCM_OBS_AM_PM_DIG: return {1'b1, ch[3], 1'b1, ch[2]};
			`RCM_OBS_COLL: return {1'b1, ch[1], 2'b00};
			`RCM_OBS_TXMOD: return {1'b1, ch[0], 2'b00};
			default: return 4'h0;
		endcase
	endfunction

	// ==================================================
	// sub-blocks
	rcm_if bus();

	rcm_link u_link (
		.i_sclk(i_sclk),
		.i_rstn(i_rstn),
		.i_cmd_stb(i_lk_cmd_stb),
		.i_cmd(i_lk_cmd),
		.i_wr_stb(i_lk_wr_stb),
		.i_addr(i_lk_addr),
		.i_wdata(i_lk_wdata),
		.lk(bus.lnk)
	);

	rcm_regadj #(
		.WAIT_CYC(REG_WAIT_CYC),
		.TOTAL_CYC(REG_TOTAL_CYC)
	) u_regadj (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.ra(bus.seq)
	);

	// ==================================================
	// synchronisers: ss, cmd toggle, wr toggle, then analog levels
	localparam int SYN_W = 10;
	logic [SYN_W-1:0] syn1_ff;
	logic [SYN_W-1:0] syn2_ff;
	logic [2:0] syn3_ff;
	wire [SYN_W-1:0] async_in = {i_ss_n, bus.lk_cmd_tgl, bus.lk_wr_tgl, i_osc_stable, i_margin_ok,
		i_tank_above, i_am_dig, i_pm_dig, i_coll_out, i_tx_mod};

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			syn1_ff <= 10'h200;
			syn2_ff <= 10'h200;
			syn3_ff <= 3'h4;
		end else if (i_ce) begin
			syn1_ff <= async_in;
			syn2_ff <= syn1_ff;
			syn3_ff <= syn2_ff[9:7];
		end
	end

	wire ss_n_s = syn2_ff[9];
	wire ss_rise = ss_n_s && !syn3_ff[2];
	wire cmd_new = syn2_ff[8] ^ syn3_ff[1];
	wire wr_new = syn2_ff[7] ^ syn3_ff[0];
	wire osc_ok_s = syn2_ff[6];
	wire margin_s = syn2_ff[5];
	wire tank_s = syn2_ff[4];
	wire [3:0] chan_s = syn2_ff[3:0];

	// ==================================================
	// command decode and acceptance
	rcm_state_e st_ff;
	wire [7:0] cmd = bus.lk_cmd;
	wire ready = i_en && osc_ok_s;
	wire idle = (st_ff == ST_IDLE);
	wire go = cmd_new && ready && idle;
	wire hit_adj = go && (cmd == `RCM_CMD_ADJ_REG) && !i_ext_reg_sel;
	wire hit_mod = go && (cmd == `RCM_CMD_CAL_MOD);
	wire hit_ant = go && (cmd == `RCM_CMD_CAL_ANT);
	wire hit_ph = go && (cmd == `RCM_CMD_MEAS_PHASE);
	wire hit_sup = go && (cmd == `RCM_CMD_MEAS_SUPPLY);
	wire hit_clr_sig = cmd_new && ready && (cmd == `RCM_CMD_CLR_SIG);
	wire hit_transp = cmd_new && ready && (cmd == `RCM_CMD_TRANSP);
	wire hit_test = cmd_new && (cmd == `RCM_CMD_TEST_ACCESS);
	wire hit_clr_test = cmd_new && (cmd == `RCM_CMD_CLR_TEST);

	assign bus.ce = i_ce;
	assign bus.ra_start = hit_adj;
	assign bus.ra_is5v = i_supply_5v;
	assign bus.ra_margin_ok = margin_s;

	// ==================================================
	// sequencer
	rcm_cnt_t tmo_ff;
	rcm_cnt_t step_ff;
	logic [2:0] bit_ff;
	logic [7:0] depth_ff;
	logic [7:0] trim_ff;
	logic [7:0] result_ff;
	logic irq_ff;
	logic adc_start_ff;
	logic [1:0] adc_src_ff;
	logic phase_ff;

	wire tmo_end = (tmo_ff == 20'h00000);
	wire step_end = (step_ff == 20'h00000);
	wire depth_hit = i_adc_done && (i_adc_data == i_md_target);
	wire mod_end = depth_hit || tmo_end;
	wire meas_end = i_adc_done || tmo_end;
	wire [7:0] bit_mask = 8'h01 << bit_ff;
	wire [7:0] trim_kept = tank_s ? trim_ff : (trim_ff & ~bit_mask);
	wire [7:0] depth_dn = (depth_ff == 8'h00) ? depth_ff : depth_ff - 8'h01;
	wire [7:0] depth_up = (depth_ff == 8'hFF) ? depth_ff : depth_ff + 8'h01;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_ff <= ST_IDLE;
			tmo_ff <= 20'h00000;
			step_ff <= 20'h00000;
			bit_ff <= 3'h0;
			irq_ff <= 1'b0;
			adc_start_ff <= 1'b0;
			adc_src_ff <= `RCM_ADC_SRC_NONE;
			phase_ff <= 1'b0;
		end else if (i_ce) begin
			irq_ff <= 1'b0;
			adc_start_ff <= 1'b0;
			tmo_ff <= tmo_end ? tmo_ff : tmo_ff - 20'h00001;
			step_ff <= step_end ? step_ff : step_ff - 20'h00001;
			case (st_ff)
				ST_IDLE: begin
					adc_src_ff <= `RCM_ADC_SRC_NONE;
					if (hit_adj) begin
						st_ff <= ST_REG;
					end else if (hit_mod) begin
						st_ff <= ST_MOD;
						tmo_ff <= 20'(MOD_CYC - 1);
						step_ff <= 20'h00000;
						adc_src_ff <= `RCM_ADC_SRC_DEPTH;
					end else if (hit_ant) begin
						st_ff <= ST_ANT;
						step_ff <= 20'(ANT_STEP_CYC - 1);
						bit_ff <= 3'h7;
					end else if (hit_ph || hit_sup) begin
						st_ff <= ST_MEAS;
						tmo_ff <= 20'(MEAS_CYC - 1);
						adc_start_ff <= 1'b1;
						adc_src_ff <= hit_ph ? `RCM_ADC_SRC_PHASE : `RCM_ADC_SRC_SUPPLY;
						phase_ff <= hit_ph;
					end
				end
				ST_REG: begin
					if (bus.ra_done) begin
						st_ff <= ST_IDLE;
						irq_ff <= 1'b1;
					end
				end
				ST_MOD: begin
					if (step_end) begin
						adc_start_ff <= 1'b1;
						step_ff <= 20'(MOD_STEP_CYC - 1);
					end
					if (mod_end) begin
						st_ff <= ST_IDLE;
						irq_ff <= 1'b1;
					end
				end
				ST_ANT: begin
					if (step_end) begin
						step_ff <= 20'(ANT_STEP_CYC - 1);
						bit_ff <= bit_ff - 3'h1;
						// antenna calibration ends silently, no termination pulse
						if (bit_ff == 3'h0)
							st_ff <= ST_IDLE;
					end
				end
				ST_MEAS: begin
					if (meas_end) begin
						st_ff <= ST_IDLE;
						irq_ff <= 1'b1;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// ==================================================
	// calibration values and converter result
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			depth_ff <= 8'h00;
			trim_ff <= `RCM_TRIM_MID;
			result_ff <= 8'h00;
		end else if (i_ce) begin
			if (st_ff == ST_MOD && i_adc_done && !depth_hit)
				depth_ff <= (i_adc_data > i_md_target) ? depth_dn : depth_up;
			if (hit_ant)
				trim_ff <= `RCM_TRIM_MID;
			else if (st_ff == ST_ANT && step_end)
				trim_ff <= (bit_ff == 3'h0) ? trim_kept : (trim_kept | (bit_mask >> 1));
			if (st_ff == ST_MEAS && i_adc_done)
				result_ff <= phase_ff ? phase_code(i_adc_over, i_adc_under, i_adc_data) : i_adc_data;
		end
	end

	// ==================================================
	// analog enables follow the sequencer state
	logic rx_force_ff;
	logic tx_force_ff;
	logic phase_en_ff;
	logic [1:0] supply_ch_ff;
	logic [12:0] reg_mv_ff;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rx_force_ff <= 1'b0;
			tx_force_ff <= 1'b0;
			phase_en_ff <= 1'b0;
			supply_ch_ff <= 2'h0;
			reg_mv_ff <= 13'h0000;
		end else if (i_ce) begin
			rx_force_ff <= bus.ra_busy;
			tx_force_ff <= bus.ra_busy || (st_ff == ST_MOD) || (st_ff == ST_MEAS && phase_ff);
			phase_en_ff <= (st_ff == ST_MEAS) && phase_ff;
			supply_ch_ff <= {i_supply_measure_select_hi, i_supply_measure_select_lo};
			reg_mv_ff <= bus.ra_mv;
		end
	end

	// ==================================================
	// peak-hold signal strength
	logic rx_on_d_ff;
	logic [3:0] sig_ff;
	wire rx_rise = i_rx_on && !rx_on_d_ff;
	wire sig_higher = i_rx_on && (i_sig_level > sig_ff);
	wire [3:0] nxt_sig = (rx_rise || hit_clr_sig) ? 4'h0 : (sig_higher ? i_sig_level : sig_ff);

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rx_on_d_ff <= 1'b0;
			sig_ff <= 4'h0;
		end else if (i_ce) begin
			rx_on_d_ff <= i_rx_on;
			sig_ff <= nxt_sig;
		end
	end

	// ==================================================
	// transparent mode and test access, both tied to the frame
	logic transp_arm_ff;
	logic transp_ff;
	logic test_ff;
	logic [7:0] obs_reg_ff;
	wire obs_wr = wr_new && test_ff && (bus.lk_addr == `RCM_TADDR_OBS);

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			transp_arm_ff <= 1'b0;
			transp_ff <= 1'b0;
			test_ff <= 1'b0;
		end else if (i_ce) begin
			transp_arm_ff <= hit_transp || (transp_arm_ff && !ss_rise);
			transp_ff <= (transp_arm_ff && ss_rise) || (transp_ff && ss_n_s);
			// a test access command opens the test space for the rest of its frame
			test_ff <= hit_test || (test_ff && !ss_rise);
		end
	end

	// only reset and the clear command clear the test register, never a frame end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			obs_reg_ff <= `RCM_OBS_RESET;
		else if (i_ce) begin
			if (hit_clr_test)
				obs_reg_ff <= `RCM_OBS_RESET;
			else if (obs_wr)
				obs_reg_ff <= bus.lk_wdata & `RCM_OBS_WMASK;
		end
	end

	// ==================================================
	// observation pins; no test-mode gate, so they run in normal operation too
	logic [3:0] obs_pins_ff;
	wire [3:0] nxt_obs = obs_route(obs_reg_ff[3:0], chan_s);

	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			obs_pins_ff <= 4'h0;
		else if (i_ce)
			obs_pins_ff <= nxt_obs;
	end

	// ==================================================
	// outputs
	assign o_rx_force = rx_force_ff;
	assign o_tx_force = tx_force_ff;
	assign o_phase_det_en = phase_en_ff;
	assign o_adc_start = adc_start_ff;
	assign o_adc_src = adc_src_ff;
	assign o_adc_rel = (adc_src_ff == `RCM_ADC_SRC_PHASE);
	assign o_supply_ch = supply_ch_ff;
	assign o_reg_mv = reg_mv_ff;
	assign o_mod_depth = depth_ff;
	assign o_tuning_trim_outputs = trim_ff;
	assign o_adc_result = result_ff;
	assign o_irq_term = irq_ff;
	assign o_busy = !idle;
	assign o_signal_strength = sig_ff;
	assign o_transparent = transp_ff;
	assign o_test_active = test_ff;
	assign o_test_rdata = obs_reg_ff;
	assign o_obs_sel = obs_reg_ff[3:0];
	assign o_observe_pin_a_oe = obs_pins_ff[3];
	assign o_observe_pin_a = obs_pins_ff[2];
	assign o_observe_pin_b_oe = obs_pins_ff[1];
	assign o_observe_pin_b = obs_pins_ff[0];
endmodule // rcm_top
`default_nettype wire

/* common/rcm_defines.svh */
// constants of the calibration and measurement command block
`ifndef RCM_DEFINES_SVH
`define RCM_DEFINES_SVH

// ==================================================
// clock and time figures
`define RCM_CLK_MHZ 200
`define RCM_US2CYC(us) ((us) * `RCM_CLK_MHZ)
`define RCM_REG_WAIT_US 300
`define RCM_REG_TOTAL_US 5000
`define RCM_MOD_TOTAL_US 275
`define RCM_MOD_STEP_US 1
`define RCM_ANT_TOTAL_US 250
`define RCM_MEAS_TOTAL_US 25

// ==================================================
// regulator figures in millivolts
`define RCM_REG_MAX_MV_5V 5100
`define RCM_REG_MIN_MV_5V 3900
`define RCM_REG_STEP_MV_5V 120
`define RCM_REG_MAX_MV_3V3 3400
`define RCM_REG_MIN_MV_3V3 2400
`define RCM_REG_STEP_MV_3V3 100

// ==================================================
// command codes (arbitrary values)
`define RCM_CMD_ADJ_REG 8'hD6
`define RCM_CMD_CAL_MOD 8'hD7
`define RCM_CMD_CAL_ANT 8'hD8
`define RCM_CMD_MEAS_PHASE 8'hD9
`define RCM_CMD_CLR_SIG 8'hDA
`define RCM_CMD_TRANSP 8'hDB
`define RCM_CMD_MEAS_SUPPLY 8'hDC
`define RCM_CMD_TEST_ACCESS 8'hFC
`define RCM_CMD_CLR_TEST 8'hFD

// ==================================================
// test register space
`define RCM_TADDR_OBS 6'h01
`define RCM_OBS_RESET 8'h00
`define RCM_OBS_WMASK 8'hEF

// ==================================================
// observation select codes
`define RCM_OBS_AM 4'h1
`define RCM_OBS_PM 4'h2
`define RCM_OBS_AM_PM_ANA 4'h3
`define RCM_OBS_AM_PM_DIG 4'h4
`define RCM_OBS_STAGES 4'h5
`define RCM_OBS_COLL 4'h6
`define RCM_OBS_TXMOD 4'h8
`define RCM_OBS_AM2 4'h9

// ==================================================
// converter
`define RCM_ADC_SRC_NONE 2'h0
`define RCM_ADC_SRC_DEPTH 2'h1
`define RCM_ADC_SRC_PHASE 2'h2
`define RCM_ADC_SRC_SUPPLY 2'h3
`define RCM_PHASE_SAT_HI 8'hFF
`define RCM_PHASE_SAT_LO 8'h00
`define RCM_TRIM_MID 8'h80

`endif

/* common/rcm_pkg.sv */
// types of the calibration and measurement command block
package rcm_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_REG, ST_MOD, ST_ANT, ST_MEAS} rcm_state_e;
	typedef logic [19:0] rcm_cnt_t;
	typedef logic [12:0] rcm_mv_t;
endpackage

/* common/rcm_if.sv */
// carrier between the command core, the regulator sequencer and the link capture
`timescale 1ns/1ps
`default_nettype none
interface rcm_if;
	logic ce;
	logic ra_start;
	logic ra_is5v;
	logic ra_margin_ok;
	logic ra_busy;
	logic ra_done;
	logic [12:0] ra_mv;
	logic lk_cmd_tgl;
	logic [7:0] lk_cmd;
	logic lk_wr_tgl;
	logic [5:0] lk_addr;
	logic [7:0] lk_wdata;
	modport ctl(output ce, ra_start, ra_is5v, ra_margin_ok,
		input ra_busy, ra_done, ra_mv, lk_cmd_tgl, lk_cmd, lk_wr_tgl, lk_addr, lk_wdata);
	modport seq(input ce, ra_start, ra_is5v, ra_margin_ok, output ra_busy, ra_done, ra_mv);
	modport lnk(output lk_cmd_tgl, lk_cmd, lk_wr_tgl, lk_addr, lk_wdata);
endinterface
`default_nettype wire

/* core/rcm_link.sv */
// link clock capture of command and test register write bytes
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module rcm_link (
	// link clock
	input wire logic i_sclk,
	input wire logic i_rstn,
	// bytes from the serial decoder
	input wire logic i_cmd_stb,
	input wire logic [7:0] i_cmd,
	input wire logic i_wr_stb,
	input wire logic [5:0] i_addr,
	input wire logic [7:0] i_wdata,
	// toward the core domain
	rcm_if.lnk lk
);
	logic cmd_tgl_ff;
	logic wr_tgl_ff;
	logic [7:0] cmd_ff;
	logic [5:0] addr_ff;
	logic [7:0] wdata_ff;

	// ==================================================
	// toggle per event; the held byte stays put for the eight link clocks
	// of the next byte, far longer than the core needs to see the toggle
	always_ff @(posedge i_sclk) begin
		if (!i_rstn) begin
			cmd_tgl_ff <= 1'b0;
			cmd_ff <= 8'h00;
		end else if (i_cmd_stb) begin
			cmd_tgl_ff <= ~cmd_tgl_ff;
			cmd_ff <= i_cmd;
		end
	end

	always_ff @(posedge i_sclk) begin
		if (!i_rstn) begin
			wr_tgl_ff <= 1'b0;
			addr_ff <= 6'h00;
			wdata_ff <= 8'h00;
		end else if (i_wr_stb) begin
			wr_tgl_ff <= ~wr_tgl_ff;
			addr_ff <= i_addr;
			wdata_ff <= i_wdata;
		end
	end

	assign lk.lk_cmd_tgl = cmd_tgl_ff;
	assign lk.lk_cmd = cmd_ff;
	assign lk.lk_wr_tgl = wr_tgl_ff;
	assign lk.lk_addr = addr_ff;
	assign lk.lk_wdata = wdata_ff;
endmodule // rcm_link
`default_nettype wire

/* core/rcm_regadj.sv */
// regulator adjustment sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module rcm_regadj import rcm_pkg::*; #(
	parameter int unsigned WAIT_CYC = `RCM_US2CYC(`RCM_REG_WAIT_US),
	parameter int unsigned TOTAL_CYC = `RCM_US2CYC(`RCM_REG_TOTAL_US)
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// control from the core
	rcm_if.seq ra
);
	function automatic logic [3:0] reg_steps(input logic is5v);
		int unsigned n;
		n = is5v ? (`RCM_REG_MAX_MV_5V - `RCM_REG_MIN_MV_5V) / `RCM_REG_STEP_MV_5V
			: (`RCM_REG_MAX_MV_3V3 - `RCM_REG_MIN_MV_3V3) / `RCM_REG_STEP_MV_3V3;
		return n[3:0];
	endfunction

	function automatic rcm_mv_t reg_mv(input logic is5v, input logic [3:0] code);
		int unsigned mv;
		mv = is5v ? `RCM_REG_MIN_MV_5V + code * `RCM_REG_STEP_MV_5V
			: `RCM_REG_MIN_MV_3V3 + code * `RCM_REG_STEP_MV_3V3;
		return mv[12:0];
	endfunction

	logic busy_ff;
	logic done_ff;
	logic [3:0] code_ff;
	rcm_cnt_t wait_ff;
	rcm_cnt_t tot_ff;

	wire tick = busy_ff && (wait_ff == 20'h00000);
	wire timeout = busy_ff && (tot_ff == 20'h00000);
	wire at_floor = (code_ff == 4'h0);
	wire finish = (tick && (ra.ra_margin_ok || at_floor)) || timeout;

	// ==================================================
	// step down one notch per compare until margin or floor
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			code_ff <= 4'h0;
			wait_ff <= 20'h00000;
			tot_ff <= 20'h00000;
		end else if (ra.ce) begin
			done_ff <= 1'b0;
			if (ra.ra_start) begin
				busy_ff <= 1'b1;
				code_ff <= reg_steps(ra.ra_is5v);
				wait_ff <= 20'(WAIT_CYC - 1);
				tot_ff <= 20'(TOTAL_CYC - 1);
			end else if (busy_ff) begin
				done_ff <= finish;
				busy_ff <= !finish;
				tot_ff <= tot_ff - 20'h00001;
				if (tick && !finish) begin
					code_ff <= code_ff - 4'h1;
					wait_ff <= 20'(WAIT_CYC - 1);
				end else begin
					wait_ff <= wait_ff - 20'h00001;
				end
			end
		end
	end

	assign ra.ra_busy = busy_ff;
	assign ra.ra_done = done_ff;
	assign ra.ra_mv = reg_mv(ra.ra_is5v, code_ff);
endmodule // rcm_regadj
`default_nettype wire

/* verification/rcm_host.sv */
// host model sending command and test write bytes over the link
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module rcm_host (
	// link side
	output logic o_sclk,
	output logic o_ss_n,
	output logic o_cmd_stb,
	output logic o_wr_stb,
	output logic [7:0] o_cmd,
	output logic [5:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		{o_sclk, o_cmd_stb, o_wr_stb, o_cmd, o_addr, o_wdata} = '0;
		o_ss_n = 1'b1;
	end
	// link clock stands still outside frames, except for the four clocks given during reset
	task automatic tick(input int n);
		repeat (n) begin
			#3 o_sclk = 1'b1;
			#3 o_sclk = 1'b0;
		end
	endtask
	// one byte per eight clocks; released data lines show the inverse
	task automatic put(input bit w, input logic [7:0] b);
		{o_cmd_stb, o_wr_stb} = {!w, w};
		{o_cmd, o_wdata, o_addr} = {b, b, `RCM_TADDR_OBS};
		tick(1);
		{o_cmd_stb, o_wr_stb} = 2'b00;
		{o_cmd, o_wdata} = ~{b, b};
		tick(7);
	endtask
	// a long command always travels alone in its frame
	task automatic frame(input logic [7:0] c, input bit w, input logic [7:0] d);
		o_ss_n = 1'b0;
		tick(2);
		put(1'b0, c);
		if (w) put(1'b1, d);
		tick(2);
		o_ss_n = 1'b1;
	endtask
endmodule // rcm_host
`default_nettype wire

/* verification/rcm_top_assertions.sv */
// concurrent checks on the ports of the command block
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module rcm_top_assertions (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// watched ports
	input wire logic i_supply_5v,
	input wire logic i_rx_on,
	input wire logic o_rx_force,
	input wire logic o_tx_force,
	input wire logic o_phase_det_en,
	input wire logic o_adc_rel,
	input wire logic [1:0] o_adc_src,
	input wire logic [12:0] o_reg_mv,
	input wire logic o_irq_term,
	input wire logic [3:0] o_signal_strength,
	input wire logic [7:0] o_test_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// ==========================================
	// sequences
	sequence s_phase_on;
		$rose(o_phase_det_en);
	endsequence
	sequence s_step;
		o_rx_force && $past(o_rx_force) && $changed(o_reg_mv);
	endsequence
	// ==========================================
	// properties
	AST_IRQ_PULSE: assert property (o_irq_term |=> !o_irq_term)
		else $error("termination pulse too long");
	AST_REL_MODE: assert property (o_phase_det_en |-> o_adc_rel)
		else $error("converter mode wrong");
	AST_PHASE_TX: assert property (s_phase_on |-> ##[0:2] (o_tx_force && o_adc_src == `RCM_ADC_SRC_PHASE))
		else $error("phase path not set up");
	AST_REG_RANGE: assert property (o_rx_force |-> (i_supply_5v ?
		o_reg_mv inside {[3900:5100]} : o_reg_mv inside {[2400:3400]}))
		else $error("regulator setting out of range");
	AST_REG_STEP: assert property (s_step |-> $past(o_reg_mv) - o_reg_mv == (i_supply_5v ? 120 : 100))
		else $error("regulator step wrong");
	AST_PEAK_HOLD: assert property (o_signal_strength < $past(o_signal_strength) |-> o_signal_strength == 0)
		else $error("strength fell without clear");
	AST_RX_CLEAR: assert property ($rose(i_rx_on) |=> o_signal_strength == 4'h0)
		else $error("strength not cleared");
	AST_TEST_BIT4: assert property (!o_test_rdata[4])
		else $error("unused test bit set");
endmodule // rcm_top_assertions
bind rcm_top rcm_top_assertions u_rcm_chk (.i_clk, .i_rstn, .i_supply_5v, .i_rx_on, .o_rx_force, .o_tx_force,
	.o_phase_det_en, .o_adc_rel, .o_adc_src, .o_reg_mv, .o_irq_term, .o_signal_strength, .o_test_rdata);
`default_nettype wire

/* verification/test_reader_calibration_measure_commands.sv */
// self-checking bench of the calibration and measurement command block
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"
module test_reader_calibration_measure_commands;
	logic i_clk = 0, i_rstn = 0, i_ce = 1, i_en = 0, i_ext_reg_sel = 0, i_supply_5v = 0, i_osc_stable = 1;
	logic i_supply_measure_select_hi = 0, i_supply_measure_select_lo = 0, i_margin_ok = 0, i_tank_above = 0;
	logic i_am_dig = 0, i_pm_dig = 0, i_coll_out = 0, i_tx_mod = 0, i_adc_done = 0, i_adc_over = 0;
	logic i_adc_under = 0, i_rx_on = 0, i_sclk, i_ss_n, i_lk_cmd_stb, i_lk_wr_stb;
	logic [7:0] i_md_target = 0, i_adc_data = 0, i_lk_cmd, i_lk_wdata;
	logic [5:0] i_lk_addr;
	logic [3:0] i_sig_level = 0;
	logic o_rx_force, o_tx_force, o_phase_det_en, o_adc_start, o_adc_rel, o_irq_term, o_busy, o_transparent;
	logic o_test_active, o_observe_pin_a, o_observe_pin_a_oe, o_observe_pin_b, o_observe_pin_b_oe;
	logic [1:0] o_adc_src, o_supply_ch;
	logic [12:0] o_reg_mv;
	logic [7:0] o_mod_depth, o_tuning_trim_outputs, o_adc_result, o_test_rdata;
	logic [3:0] o_signal_strength, o_obs_sel;
	int errors = 0, num_checks = 0;
	// short counts keep the run brief
	rcm_top #(.REG_WAIT_CYC(20), .REG_TOTAL_CYC(400), .MOD_CYC(300), .ANT_CYC(80), .MEAS_CYC(50)) dut (.*);
	rcm_host host (.o_sclk(i_sclk), .o_ss_n(i_ss_n), .o_cmd_stb(i_lk_cmd_stb), .o_wr_stb(i_lk_wr_stb),
		.o_cmd(i_lk_cmd), .o_addr(i_lk_addr), .o_wdata(i_lk_wdata));
	always #2.5 i_clk = ~i_clk;
	// ==========================================
	// helpers
	task automatic close_out;
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// bounded wait; a hang ends the run as a mismatch
	task automatic until_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			@(posedge i_clk);
			n++;
			if (n > 3000) begin
				errors++;
				close_out();
			end
		end
	endtask
	function automatic logic [12:0] reg_exp(input logic v5, input logic ok);
		if (v5) return ok ? `RCM_REG_MAX_MV_5V : `RCM_REG_MIN_MV_5V;
		return ok ? `RCM_REG_MAX_MV_3V3 : `RCM_REG_MIN_MV_3V3;
	endfunction
	// ==========================================
	// scenarios
	initial begin
		int k;
		logic [7:0] d;
		logic [3:0] a, b;
		void'($urandom(32'hFE8F));
		fork
			host.tick(4);
			cyc(16);
		join
		i_rstn <= 1'b1;
		i_md_target <= 8'($urandom);
		i_tank_above <= 1'($urandom);
		cyc(2);
		chk("trim", o_tuning_trim_outputs, `RCM_TRIM_MID);
		for (k = 0; k < 3; k++) begin
			i_en <= k != 0;
			i_osc_stable <= k != 1;
			i_ext_reg_sel <= k == 2;
			cyc(4);
			host.frame(k == 2 ? `RCM_CMD_ADJ_REG : `RCM_CMD_MEAS_PHASE, 1'b0, 8'h00);
			cyc(20);
			chk("busy", o_busy, 0);
			chk("regmv", o_reg_mv, reg_exp(i_supply_5v, 1'b0));
		end
		i_ext_reg_sel <= 1'b0;
		i_osc_stable <= 1'b1;
		host.frame(`RCM_CMD_CAL_ANT, 1'b0, 8'h00);
		cyc(90);
		chk("ant", o_tuning_trim_outputs, {8{i_tank_above}});
		host.frame(`RCM_CMD_CAL_MOD, 1'b0, 8'h00);
		for (k = 0; k < 2; k++) begin
			{i_adc_data, i_adc_done} <= {k ? i_md_target : ~i_md_target, 1'b1};
			cyc(1);
			i_adc_done <= 1'b0;
			cyc(1);
		end
		chk("depth", o_mod_depth, ~i_md_target < i_md_target);
		for (k = 0; k < 5; k++) begin
			d = (k == 0) ? 8'h80 : 8'($urandom);
			{i_supply_measure_select_hi, i_supply_measure_select_lo} <= d[1:0];
			host.frame(k < 3 ? `RCM_CMD_MEAS_PHASE : `RCM_CMD_MEAS_SUPPLY, 1'b0, 8'h00);
			until_hi(o_busy);
			chk("src", o_adc_src, k < 3 ? `RCM_ADC_SRC_PHASE : `RCM_ADC_SRC_SUPPLY);
			chk("pdet", o_phase_det_en, k < 3);
			if (k > 2) chk("supch", o_supply_ch, d[1:0]);
			{i_adc_over, i_adc_under, i_adc_data, i_adc_done} <= {k == 1, k == 2, d, 1'b1};
			cyc(1);
			i_adc_done <= 1'b0;
			until_hi(o_irq_term);
			chk("adc", o_adc_result, k == 1 ? `RCM_PHASE_SAT_LO : k == 2 ? `RCM_PHASE_SAT_HI : d);
		end
		for (k = 0; k < 2; k++) begin
			i_supply_5v <= 1'($urandom);
			i_margin_ok <= k[0];
			host.frame(`RCM_CMD_ADJ_REG, 1'b0, 8'h00);
			until_hi(o_rx_force);
			chk("regmax", o_reg_mv, reg_exp(i_supply_5v, 1'b1));
			until_hi(o_irq_term);
			chk("regend", o_reg_mv, reg_exp(i_supply_5v, k[0]));
		end
		d = (8'($urandom) & 8'hF0) | 8'h06;
		host.frame(`RCM_CMD_TEST_ACCESS, 1'b1, d);
		cyc(6);
		chk("tw", o_test_rdata, d & `RCM_OBS_WMASK);
		host.frame(8'h00, 1'b1, 8'h03);
		cyc(6);
		chk("tkeep", o_test_rdata, d & `RCM_OBS_WMASK);
		for (k = 0; k < 2; k++) begin
			i_coll_out <= k[0];
			cyc(6);
			chk("obs", {o_observe_pin_a_oe, o_observe_pin_a}, {1'b1, k[0]});
		end
		host.frame(`RCM_CMD_CLR_TEST, 1'b0, 8'h00);
		cyc(6);
		chk("tclr", o_test_rdata, `RCM_OBS_RESET);
		a = 4'($urandom);
		b = 4'($urandom);
		{i_rx_on, i_sig_level} <= {1'b1, a};
		cyc(3);
		i_sig_level <= b;
		cyc(3);
		chk("peak", o_signal_strength, a > b ? a : b);
		i_sig_level <= 4'h0;
		host.frame(`RCM_CMD_CLR_SIG, 1'b0, 8'h00);
		cyc(2);
		chk("sclr", o_signal_strength, 0);
		host.frame(`RCM_CMD_TRANSP, 1'b0, 8'h00);
		cyc(6);
		chk("transp", o_transparent, 1);
		close_out();
	end
endmodule // test_reader_calibration_measure_commands
`default_nettype wire
